// [hw/ttc_codec.v]
// Two-track tape format encoder and decoder
// What this block does
// - Bit value selects track; decoder reads track
// - Marks write zeros, track zero only
// - Record mark: four widely spaced reversals
// - File mark: eight widely spaced reversals
// - Bits within a character 21 us apart
// - Characters 70 us apart
// - Gap after record data up to 130 us
// - Normalizing gap after mark at most 100 us
// - Interrecord gap 65 ms
// - Interfile gap 195 ms
// - Erase at least 300 ms after last file
// - 256 bytes per record, 128 selectable
// - Files hold at least three records, marks delimit
// - Gap times assume 30 inches per second
`include "ttc_consts.vh"
module ttc_codec #(
	parameter IRG_CYC = `TTC_IRG_CYC,
	parameter IFG_CYC = `TTC_IFG_CYC,
	parameter ERASE_CYC = `TTC_ERASE_CYC
) (
	input wire clk,
	input wire resetn,
	input wire cmdValid,
	input wire [1:0] cmdOp,
	input wire recShort,
	output reg cmdReady,
	output reg shortFile,
	input wire srcValid,
	input wire [7:0] srcData,
	output wire srcReady,
	output reg wrFlux0,
	output reg wrFlux1,
	output reg eraseOn,
	input wire rdFlux0,
	input wire rdFlux1,
	output wire sinkValid,
	output wire [7:0] sinkData,
	input wire sinkReady,
	output reg recMark,
	output reg fileMark,
	output reg rxOverrun
);
	localparam ST_IDLE = 3'h0;
	localparam ST_FETCH = 3'h1;
	localparam ST_BIT = 3'h2;
	localparam ST_MARK = 3'h3;
	localparam ST_WAIT = 3'h4;
	localparam ST_IRG = 3'h5;
	localparam ST_IFG = 3'h6;
	localparam [22:0] BIT_LD = `TTC_INTERBIT_CYC - 1;
	localparam [22:0] CHAR_LD = `TTC_INTERCHAR_CYC - 1;
	localparam [22:0] FIRST_LD = `TTC_FIRSTGAP_CYC - 1;
	localparam [22:0] NORM_LD = `TTC_NORM_CYC - 1;
	localparam [22:0] IRG_LD = IRG_CYC - 1;
	localparam [22:0] IFG_LD = IFG_CYC - 1;
	localparam [22:0] ERASE_LD = ERASE_CYC - 1;
	localparam [12:0] THRESH = `TTC_THRESH_CYC;
	localparam [12:0] TIMEOUT = `TTC_TIMEOUT_CYC;

	reg [1:0] rstSync_q;
	wire rstn = rstSync_q[1];

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end

	// Encoder side
	wire txValid;
	wire [7:0] txData;
	wire txPop;
	reg [2:0] st_q;
	reg [2:0] next_q;
	reg [22:0] timer_q;
	reg [7:0] sh_q;
	reg [3:0] bitLeft_q;
	reg [8:0] byteCnt_q;
	reg [3:0] markLeft_q;
	reg isFile_q;
	reg [1:0] recCnt_q;
	wire [8:0] recLen = recShort ? 9'd`TTC_REC_SHORT : 9'h100;

	assign txPop = (st_q == ST_FETCH);

	ttc_buf #(
		.WIDTH(8)
	) txBuf (
		.clk(clk),
		.rstn(rstn),
		.inValid(srcValid),
		.inData(srcData),
		.inReady(srcReady),
		.outValid(txValid),
		.outData(txData),
		.outReady(txPop)
	);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= ST_IDLE;
			next_q <= ST_IDLE;
			timer_q <= 23'h0;
			sh_q <= 8'h0;
			bitLeft_q <= 4'h0;
			byteCnt_q <= 9'h0;
			markLeft_q <= 4'h0;
			isFile_q <= 1'b0;
			recCnt_q <= 2'h0;
			cmdReady <= 1'b0;
			shortFile <= 1'b0;
			wrFlux0 <= 1'b0;
			wrFlux1 <= 1'b0;
			eraseOn <= 1'b0;
		end else begin
			shortFile <= 1'b0;
			cmdReady <= 1'b0;
			case (st_q)
			ST_IDLE: begin
				eraseOn <= 1'b0;
				cmdReady <= 1'b1;
				if (cmdValid && cmdReady) begin
					cmdReady <= 1'b0;
					case (cmdOp)
					`TTC_OP_RECORD: begin
						byteCnt_q <= 9'h0;
						st_q <= ST_FETCH;
					end
					`TTC_OP_FILE: begin
						if (recCnt_q < 2'd`TTC_MIN_RECS) begin
							shortFile <= 1'b1;
						end else begin
							markLeft_q <= 4'd`TTC_MARK_FILE;
							isFile_q <= 1'b1;
							st_q <= ST_MARK;
						end
					end
					`TTC_OP_ERASE: begin
						eraseOn <= 1'b1;
						timer_q <= ERASE_LD;
						next_q <= ST_IDLE;
						st_q <= ST_WAIT;
					end
					default: begin
						st_q <= ST_IDLE;
					end
					endcase
				end
			end
			ST_FETCH: begin
				if (txValid) begin
					sh_q <= txData;
					bitLeft_q <= 4'h8;
					st_q <= ST_BIT;
				end
			end
			ST_BIT: begin
				if (sh_q[7]) begin
					wrFlux1 <= ~wrFlux1;
				end else begin
					wrFlux0 <= ~wrFlux0;
				end
				sh_q <= {sh_q[6:0], 1'b0};
				bitLeft_q <= bitLeft_q - 4'h1;
				st_q <= ST_WAIT;
				if (bitLeft_q > 4'h1) begin
					timer_q <= BIT_LD;
					next_q <= ST_BIT;
				end else if (byteCnt_q + 9'h1 == recLen) begin
					timer_q <= FIRST_LD;
					markLeft_q <= 4'd`TTC_MARK_REC;
					isFile_q <= 1'b0;
					next_q <= ST_MARK;
				end else begin
					byteCnt_q <= byteCnt_q + 9'h1;
					timer_q <= CHAR_LD;
					next_q <= ST_FETCH;
				end
			end
			ST_MARK: begin
				wrFlux0 <= ~wrFlux0;
				markLeft_q <= markLeft_q - 4'h1;
				st_q <= ST_WAIT;
				if (markLeft_q > 4'h1) begin
					timer_q <= CHAR_LD;
					next_q <= ST_MARK;
				end else if (isFile_q) begin
					// Erase starts only after the last reversal has been written
					recCnt_q <= 2'h0;
					timer_q <= 23'h1;
					next_q <= ST_IFG;
				end else begin
					timer_q <= NORM_LD;
					next_q <= ST_IRG;
				end
			end
			ST_IRG: begin
				if (recCnt_q != 2'h3) begin
					recCnt_q <= recCnt_q + 2'h1;
				end
				eraseOn <= 1'b1;
				timer_q <= IRG_LD;
				next_q <= ST_IDLE;
				st_q <= ST_WAIT;
			end
			ST_IFG: begin
				eraseOn <= 1'b1;
				timer_q <= IFG_LD;
				next_q <= ST_IDLE;
				st_q <= ST_WAIT;
			end
			ST_WAIT: begin
				if (timer_q <= 23'h1) begin
					st_q <= next_q;
				end else begin
					timer_q <= timer_q - 23'h1;
				end
			end
			default: begin
				st_q <= ST_IDLE;
			end
			endcase
		end
	end

	// Decoder side
	reg [1:0] s1_q;
	reg [1:0] s2_q;
	reg [1:0] s3_q;
	reg [1:0] lvl_q;
	reg [12:0] gap_q;
	reg [3:0] bitCnt_q;
	reg [7:0] rxSh_q;
	reg [3:0] iso_q;
	reg rxPush_q;
	reg [7:0] rxByte_q;
	wire rxReady;
	wire [1:0] rev = (s2_q ~^ s3_q) & (s3_q ^ lvl_q);
	wire anyRev = |rev;
	wire revBit = rev[1];
	wire longGap = (gap_q >= THRESH);
	wire lone = (bitCnt_q == 4'h1) && !rxSh_q[0];
	wire [3:0] isoNow = iso_q + {3'h0, lone};

	ttc_buf #(
		.WIDTH(8)
	) rxBuf (
		.clk(clk),
		.rstn(rstn),
		.inValid(rxPush_q),
		.inData(rxByte_q),
		.inReady(rxReady),
		.outValid(sinkValid),
		.outData(sinkData),
		.outReady(sinkReady)
	);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= 2'h0;
			s2_q <= 2'h0;
			s3_q <= 2'h0;
			lvl_q <= 2'h0;
			gap_q <= 13'h0;
			bitCnt_q <= 4'h0;
			rxSh_q <= 8'h0;
			iso_q <= 4'h0;
			rxPush_q <= 1'b0;
			rxByte_q <= 8'h0;
			recMark <= 1'b0;
			fileMark <= 1'b0;
			rxOverrun <= 1'b0;
		end else begin
			s1_q <= {rdFlux1, rdFlux0};
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_q ^ rev;
			rxPush_q <= 1'b0;
			recMark <= 1'b0;
			fileMark <= 1'b0;
			rxOverrun <= 1'b0;
			if (gap_q != 13'h1fff) begin
				gap_q <= gap_q + 13'h1;
			end
			if (anyRev) begin
				gap_q <= 13'h0;
				rxSh_q <= {rxSh_q[6:0], revBit};
				if (longGap) begin
					bitCnt_q <= 4'h1;
					if (lone) begin
						iso_q <= (iso_q == 4'hf) ? iso_q : isoNow;
					end else if (bitCnt_q != 4'h0) begin
						iso_q <= 4'h0;
					end
				end else if (bitCnt_q == 4'h7) begin
					bitCnt_q <= 4'h0;
					iso_q <= 4'h0;
					rxByte_q <= {rxSh_q[6:0], revBit};
					rxPush_q <= 1'b1;
					rxOverrun <= ~rxReady;
				end else begin
					bitCnt_q <= bitCnt_q + 4'h1;
				end
			end else if (gap_q == TIMEOUT) begin
				recMark <= (isoNow == 4'd`TTC_MARK_REC);
				fileMark <= (isoNow == 4'd`TTC_MARK_FILE);
				iso_q <= 4'h0;
				bitCnt_q <= 4'h0;
			end
		end
	end
endmodule

// [inc/ttc_consts.vh]
// Timing, format and command constants for the two-track tape codec
`ifndef TTC_CONSTS_VH
`define TTC_CONSTS_VH
`define TTC_CLK_MHZ 20
`define TTC_SPEED_IPS 30
`define TTC_INTERBIT_US 21
`define TTC_INTERCHAR_US 70
`define TTC_FIRSTGAP_US 100
`define TTC_NORM_US 100
`define TTC_THRESH_US 37
`define TTC_TIMEOUT_US 200
`define TTC_IRG_MS 65
`define TTC_IFG_MS 195
`define TTC_ERASE_MS 300
`define TTC_INTERBIT_CYC (`TTC_INTERBIT_US * `TTC_CLK_MHZ)
`define TTC_INTERCHAR_CYC (`TTC_INTERCHAR_US * `TTC_CLK_MHZ)
`define TTC_FIRSTGAP_CYC (`TTC_FIRSTGAP_US * `TTC_CLK_MHZ)
`define TTC_NORM_CYC (`TTC_NORM_US * `TTC_CLK_MHZ)
`define TTC_THRESH_CYC (`TTC_THRESH_US * `TTC_CLK_MHZ)
`define TTC_TIMEOUT_CYC (`TTC_TIMEOUT_US * `TTC_CLK_MHZ)
`define TTC_IRG_CYC (`TTC_IRG_MS * 1000 * `TTC_CLK_MHZ)
`define TTC_IFG_CYC (`TTC_IFG_MS * 1000 * `TTC_CLK_MHZ)
`define TTC_ERASE_CYC (`TTC_ERASE_MS * 1000 * `TTC_CLK_MHZ)
`define TTC_REC_LONG 256
`define TTC_REC_SHORT 128
`define TTC_MARK_REC 4
`define TTC_MARK_FILE 8
`define TTC_MIN_RECS 3
`define TTC_OP_RECORD 2'h0
`define TTC_OP_FILE 2'h1
`define TTC_OP_ERASE 2'h2
`endif

// [hw/ttc_buf.v]
// Two-entry buffer with registered valid and ready on both sides
module ttc_buf #(
	parameter WIDTH = 8
) (
	input wire clk,
	input wire rstn,
	input wire inValid,
	input wire [WIDTH-1:0] inData,
	output reg inReady,
	output reg outValid,
	output reg [WIDTH-1:0] outData,
	input wire outReady
);
	reg [WIDTH-1:0] spare_q;
	reg spareV_q;
	reg [WIDTH-1:0] head_d;
	reg [WIDTH-1:0] spare_d;
	reg headV_d;
	reg spareV_d;
	wire push = inValid & inReady;
	wire pop = outValid & outReady;

	always @* begin
		head_d = outData;
		spare_d = spare_q;
		headV_d = outValid;
		spareV_d = spareV_q;
		if (pop) begin
			if (spareV_q) begin
				head_d = spare_q;
				spareV_d = 1'b0;
			end else begin
				headV_d = 1'b0;
			end
		end
		if (push) begin
			if (!headV_d) begin
				head_d = inData;
				headV_d = 1'b1;
			end else begin
				spare_d = inData;
				spareV_d = 1'b1;
			end
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			outData <= {WIDTH{1'b0}};
			spare_q <= {WIDTH{1'b0}};
			outValid <= 1'b0;
			spareV_q <= 1'b0;
			inReady <= 1'b0;
		end else begin
			outData <= head_d;
			spare_q <= spare_d;
			outValid <= headV_d;
			spareV_q <= spareV_d;
			inReady <= ~spareV_d;
		end
	end
endmodule

// [bench/ttc_codec_props.sv]
// Concurrent checks on the tape codec ports
module ttc_codec_props #(
	parameter IRG_CYC = 5000,
	parameter IFG_CYC = 9000,
	parameter ERASE_CYC = 12000
) (
	input wire clk,
	input wire resetn,
	input wire cmdValid,
	input wire [1:0] cmdOp,
	input wire cmdReady,
	input wire shortFile,
	input wire wrFlux0,
	input wire wrFlux1,
	input wire eraseOn,
	input wire sinkValid,
	input wire [7:0] sinkData,
	input wire sinkReady,
	input wire recMark,
	input wire fileMark
);
	logic f0Q, f1Q;
	logic [15:0] gapQ;
	logic [23:0] eraseQ;
	logic [1:0] recsQ;
	wire flip = (wrFlux0 != f0Q) || (wrFlux1 != f1Q);
	wire take = cmdValid && cmdReady;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			f0Q <= 1'h0;
			f1Q <= 1'h0;
			gapQ <= 16'hffff;
			eraseQ <= 24'h0;
			recsQ <= 2'h0;
		end else begin
			f0Q <= wrFlux0;
			f1Q <= wrFlux1;
			gapQ <= flip ? 16'h0 : ((gapQ == 16'hffff) ? gapQ : gapQ + 16'h1);
			eraseQ <= eraseOn ? eraseQ + 24'h1 : 24'h0;
			if (take && cmdOp == 2'h0 && recsQ != 2'h3)
				recsQ <= recsQ + 2'h1;
			else if (take && cmdOp == 2'h1 && recsQ == 2'h3)
				recsQ <= 2'h0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_rec_take;
		take && cmdOp == 2'h0;
	endsequence
	sequence s_first_rev;
		##[1:6] flip;
	endsequence
	a_one_track: assert property (!($changed(wrFlux0) && $changed(wrFlux1)))
		else $error("both tracks reversed together");
	a_first_rev: assert property (s_rec_take |-> s_first_rev)
		else $error("record start wrote no reversal");
	a_bit_spacing: assert property (flip |-> gapQ >= 16'h1a3)
		else $error("reversals closer than interbit spacing");
	a_erase_quiet: assert property (eraseOn |-> !flip)
		else $error("reversal during erase gap");
	a_erase_len: assert property ($fell(eraseOn) |-> eraseQ >= IRG_CYC - 1 && eraseQ <= ERASE_CYC + 1)
		else $error("erase gap length wrong");
	a_cmd_drop: assert property (take && cmdOp != 2'h3 |=> !cmdReady)
		else $error("ready held after command");
	a_short_refuse: assert property (take && cmdOp == 2'h1 && recsQ != 2'h3 |-> ##[1:2] shortFile)
		else $error("short file not refused");
	a_short_pulse: assert property (shortFile |=> !shortFile)
		else $error("refusal pulse too long");
	a_mark_pulse: assert property (recMark || fileMark |-> !(recMark && fileMark) ##1 !(recMark || fileMark))
		else $error("mark pulse wrong");
	a_sink_hold: assert property (sinkValid && !sinkReady |=> sinkValid && $stable(sinkData))
		else $error("decoded byte dropped while stalled");
endmodule

// [bench/ttc_head_model.sv]
// Read-head model: drives flux reversals onto the two read tracks
module ttc_head_model (
	input wire clk,
	output logic rdFlux0,
	output logic rdFlux1
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rdFlux0 = 1'h0;
		rdFlux1 = 1'h0;
	end
	task automatic rev(input logic one, input int gap);
		@(negedge clk);
		if (one) rdFlux1 = !rdFlux1;
		else rdFlux0 = !rdFlux0;
		repeat (gap - 1) @(negedge clk);
	endtask
	task automatic send_byte(input logic [7:0] b, input int gap);
		for (int i = 7; i >= 0; i--) rev(b[i], gap);
	endtask
	task automatic send_mark(input int n);
		repeat (n) rev(1'b0, 1400);
	endtask
endmodule

// [bench/tb_ttc_codec.sv]
// Self-checking bench for the tape codec
module tb_ttc_codec;
	timeunit 1ns;
	timeprecision 1ns;
	localparam ER = 12000;
	logic clk, resetn, cmdValid, recShort, srcValid, sinkReady, trk;
	logic [1:0] cmdOp;
	logic [7:0] srcData;
	wire cmdReady, shortFile, srcReady, wrFlux0, wrFlux1, eraseOn;
	wire rdFlux0, rdFlux1, sinkValid, recMark, fileMark, rxOverrun;
	logic ovSeen = 1'b0;
	wire [7:0] sinkData;
	int miscompares = 0;
	int total_checks = 0;
	int c;
	ttc_codec #(.IRG_CYC(5000), .IFG_CYC(9000), .ERASE_CYC(ER)) ttc_codec_i (.clk, .resetn,
		.cmdValid, .cmdOp, .recShort, .cmdReady, .shortFile, .srcValid, .srcData, .srcReady,
		.wrFlux0, .wrFlux1, .eraseOn, .rdFlux0, .rdFlux1, .sinkValid, .sinkData, .sinkReady,
		.recMark, .fileMark, .rxOverrun);
	ttc_head_model ttc_head_model_i (.clk, .rdFlux0, .rdFlux1);
	// Overrun is a one-cycle pulse; latch it for the scenario to judge
	always @(negedge clk) if (rxOverrun === 1'b1) ovSeen <= 1'b1;
	initial begin
		clk = 1'h0;
		forever #25 clk = !clk;
	end
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task print_verdict;
		if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	function logic sig(input int s);
		case (s)
			0: return cmdReady;
			1: return eraseOn;
			2: return sinkValid;
			3: return recMark;
			4: return fileMark;
			default: return shortFile;
		endcase
	endfunction
	task wait_hi(input int s, input int n);
		c = 0;
		while (sig(s) !== 1'b1) begin
			@(negedge clk);
			c++;
			if (c > n) begin
				check("timeout", 16'h1, 16'h0);
				print_verdict;
			end
		end
	endtask
	task wait_rev;
		logic a, b;
		a = wrFlux0;
		b = wrFlux1;
		c = 0;
		while (wrFlux0 === a && wrFlux1 === b) begin
			@(negedge clk);
			c++;
			if (c > 3000) begin
				check("reversal timeout", 16'h1, 16'h0);
				print_verdict;
			end
		end
		trk = (wrFlux1 !== b);
	endtask
	task issue(input logic [1:0] op);
		wait_hi(0, 10);
		cmdOp = op;
		cmdValid = 1'h1;
		@(negedge clk);
		cmdValid = 1'h0;
	endtask
	task t_refuse;
		issue(2'h1);
		wait_hi(5, 4);
		check("refused write", {wrFlux0, wrFlux1, eraseOn}, 16'h0);
		wait_hi(0, 5);
	endtask
	task t_erase;
		int n;
		issue(2'h2);
		wait_hi(1, 5);
		n = 0;
		while (eraseOn === 1'b1 && n < ER + 10) begin
			@(negedge clk);
			n++;
		end
		check("erase cycles", n, ER);
	endtask
	task t_read;
		sinkReady = 1'h0;
		ttc_head_model_i.send_byte(8'h3c, 420);
		wait_hi(2, 3000);
		repeat (5) @(negedge clk);
		check("decoded byte", sinkData, 16'h3c);
		check("overrun before full", ovSeen, 16'h0);
		ttc_head_model_i.send_byte(8'h81, 420);
		ttc_head_model_i.send_byte(8'h42, 420);
		repeat (5) @(negedge clk);
		check("byte held while stalled", sinkData, 16'h3c);
		check("overrun when full", ovSeen, 16'h1);
		sinkReady = 1'h1;
		repeat (5000) @(negedge clk);
		check("sink drained", sinkValid, 16'h0);
		ttc_head_model_i.send_mark(4);
		wait_hi(3, 4100);
		check("file mark on record mark", fileMark, 16'h0);
		ttc_head_model_i.send_mark(8);
		wait_hi(4, 4100);
		check("record mark on file mark", recMark, 16'h0);
	endtask
	task t_record;
		srcData = 8'ha5;
		srcValid = 1'h1;
		issue(2'h0);
		for (int i = 7; i >= 0; i--) begin
			wait_rev;
			check("bit track", trk, srcData[i]);
			if (i < 7) check("bit gap", c, 16'h1a4);
		end
		wait_rev;
		check("char gap", c, 16'h579);
		check("source refused when full", srcReady, 16'h0);
		resetn = 1'h0;
		srcValid = 1'h0;
		@(negedge clk);
		check("outputs in reset", {wrFlux0, wrFlux1, eraseOn, cmdReady}, 16'h0);
		resetn = 1'h1;
		wait_hi(0, 10);
	endtask
	initial begin
		resetn = 1'h0;
		cmdValid = 1'h0;
		cmdOp = 2'h0;
		recShort = 1'h0;
		srcValid = 1'h0;
		srcData = 8'h0;
		sinkReady = 1'h0;
		repeat (2) @(negedge clk);
		resetn = 1'h1;
		t_refuse;
		t_erase;
		t_read;
		t_record;
		print_verdict;
	end
endmodule
bind ttc_codec ttc_codec_props #(.IRG_CYC(IRG_CYC), .IFG_CYC(IFG_CYC), .ERASE_CYC(ERASE_CYC))
	ttc_codec_props_i (.clk, .resetn, .cmdValid, .cmdOp, .cmdReady, .shortFile, .wrFlux0,
	.wrFlux1, .eraseOn, .sinkValid, .sinkData, .sinkReady, .recMark, .fileMark);
